// [btc_pkg.sv]
// Constants and types for the branch, trap and co-processor execution unit
package btc_pkg;
	localparam int BTC_XLEN = 32;
	localparam int BTC_OFFW = 16;
	localparam logic [4:0] BTC_LINK_REG = 5'h1f;
	localparam logic [31:0] BTC_PC_STEP = 32'h0000_0004;
	localparam logic [31:0] BTC_RESET_PC = 32'hbfc0_0000;
	localparam logic [31:0] BTC_EXC_VECTOR = 32'h8000_0080;
	// Primary opcode field values
	localparam logic [5:0] BTC_OP_SPECIAL = 6'h00;
	localparam logic [5:0] BTC_OP_BCOND = 6'h01;
	localparam logic [5:0] BTC_OP_BR_EQ = 6'h04;
	localparam logic [5:0] BTC_OP_BR_NE = 6'h05;
	localparam logic [5:0] BTC_OP_BR_NPOS = 6'h06;
	localparam logic [5:0] BTC_OP_BR_POS = 6'h07;
	localparam logic [3:0] BTC_OP_COP = 4'h4;
	localparam logic [3:0] BTC_OP_LWC = 4'hc;
	localparam logic [3:0] BTC_OP_SWC = 4'he;
	// Function field values
	localparam logic [5:0] BTC_FN_SYSTRAP = 6'h0c;
	localparam logic [5:0] BTC_FN_DBGTRAP = 6'h0d;
	// Co-processor sub-op field values (bits 25:21)
	localparam logic [4:0] BTC_CO_MF = 5'h00;
	localparam logic [4:0] BTC_CO_CF = 5'h02;
	localparam logic [4:0] BTC_CO_MT = 5'h04;
	localparam logic [4:0] BTC_CO_CT = 5'h06;
	localparam logic [4:0] BTC_CO_BC = 5'h08;
	// Exception cause codes
	localparam logic [4:0] BTC_EXC_NONE = 5'h00;
	localparam logic [4:0] BTC_EXC_SYS = 5'h08;
	localparam logic [4:0] BTC_EXC_BP = 5'h09;
	localparam logic [4:0] BTC_EXC_CPU = 5'h0b;
	// Co-processor transfer kinds
	typedef enum logic [2:0] {
		BTC_CX_NONE = 3'b000,
		BTC_CX_LOAD = 3'b001,
		BTC_CX_STORE = 3'b010,
		BTC_CX_MTD = 3'b011,
		BTC_CX_MFD = 3'b100,
		BTC_CX_MTC = 3'b101,
		BTC_CX_MFC = 3'b110,
		BTC_CX_OPER = 3'b111
	} btc_cx_e;
endpackage : btc_pkg

// [btc_branch_eval.sv]
// Branch condition and target evaluation
`timescale 1ns/1ns
`default_nettype none
module btc_branch_eval
	import btc_pkg::*;
(
	input wire logic [31:0] instr_i,
	input wire logic [31:0] slot_pc_i,
	input wire logic [31:0] rs_val_i,
	input wire logic [31:0] rt_val_i,
	input wire logic [3:0] cond_i,
	output logic is_branch_o,
	output logic taken_o,
	output logic link_o,
	output logic [31:0] target_o
);
	logic [5:0] op;
	logic [4:0] sel;
	logic neg;
	logic zero;
	assign op = instr_i[31:26];
	assign sel = instr_i[20:16];
	assign neg = rs_val_i[31];
	assign zero = (rs_val_i == 32'h0000_0000);
	assign target_o = slot_pc_i + {{14{instr_i[15]}}, instr_i[15:0], 2'b00};
	always_comb begin
		is_branch_o = 1'b0;
		taken_o = 1'b0;
		link_o = 1'b0;
		unique case (op)
			BTC_OP_BR_EQ: begin
				is_branch_o = 1'b1;
				taken_o = (rs_val_i == rt_val_i);
			end
			BTC_OP_BR_NE: begin
				is_branch_o = 1'b1;
				taken_o = (rs_val_i != rt_val_i);
			end
			BTC_OP_BR_NPOS: begin
				is_branch_o = 1'b1;
				taken_o = neg | zero;
			end
			BTC_OP_BR_POS: begin
				is_branch_o = 1'b1;
				taken_o = ~neg & ~zero;
			end
			BTC_OP_BCOND: begin
				if ((sel[3:1] == 3'b000) && !sel[4 - 1 +: 1]) begin
					is_branch_o = 1'b1;
					taken_o = sel[0] ? ~neg : neg;
					link_o = sel[4];
				end
			end
			default: begin
				if ((op[5:2] == BTC_OP_COP) && (instr_i[25:21] == BTC_CO_BC)
						&& (sel[4:1] == 4'h0)) begin
					is_branch_o = 1'b1;
					taken_o = sel[0] ? cond_i[op[1:0]] : ~cond_i[op[1:0]];
				end
			end
		endcase
	end
endmodule : btc_branch_eval
`default_nettype wire

// [btc_exec.sv]
// Branch, trap and co-processor execution unit
`timescale 1ns/1ns
`default_nettype none
module btc_exec
	import btc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic instr_valid_i,
	input wire logic [31:0] instr_i,
	input wire logic [31:0] rs_val_i,
	input wire logic [31:0] rt_val_i,
	input wire logic [3:0] branch_condition_inputs_i,
	input wire logic [31:0] mem_rdata_i,
	input wire logic [31:0] cop_rdata_i,
	output logic [31:0] pc_o,
	output logic [31:0] fetch_pc_o,
	output logic exc_o,
	output logic [4:0] exc_code_o,
	output logic reg_we_o,
	output logic [4:0] reg_waddr_o,
	output logic [31:0] reg_wdata_o,
	output logic mem_req_o,
	output logic mem_we_o,
	output logic [31:0] mem_addr_o,
	output logic [31:0] mem_wdata_o,
	output logic cop_req_o,
	output logic [1:0] cop_sel_o,
	output logic [2:0] cop_kind_o,
	output logic [4:0] cop_reg_o,
	output logic [31:0] cop_wdata_o,
	output logic [24:0] cop_func_o
);
	typedef struct packed {
		logic [31:0] pc;
		logic [31:0] fetch_pc;
		logic pend;
		logic [31:0] pend_tgt;
		logic [3:0] cond_a;
		logic [3:0] cond_b;
		logic exc;
		logic [4:0] exc_code;
		logic reg_we;
		logic [4:0] reg_waddr;
		logic [31:0] reg_wdata;
		logic mem_req;
		logic mem_we;
		logic [31:0] mem_addr;
		logic [31:0] mem_wdata;
		logic cop_req;
		logic [1:0] cop_sel;
		logic [2:0] cop_kind;
		logic [4:0] cop_reg;
		logic [31:0] cop_wdata;
		logic [24:0] cop_func;
	} btc_state_s;

	btc_state_s st_r;
	btc_state_s st_nxt;
	logic is_br;
	logic br_taken;
	logic br_link;
	logic [31:0] br_target;
	logic [31:0] slot_pc;
	logic [5:0] op;
	logic [4:0] cop_sub;
	logic [1:0] cop_z;
	logic [31:0] ls_addr;

	assign op = instr_i[31:26];
	assign cop_sub = instr_i[25:21];
	assign cop_z = op[1:0];
	assign slot_pc = st_r.pc + BTC_PC_STEP;
	assign ls_addr = rs_val_i + {{16{instr_i[15]}}, instr_i[15:0]};

	btc_branch_eval u_eval (
		.instr_i(instr_i),
		.slot_pc_i(slot_pc),
		.rs_val_i(rs_val_i),
		.rt_val_i(rt_val_i),
		.cond_i(st_r.cond_b),
		.is_branch_o(is_br),
		.taken_o(br_taken),
		.link_o(br_link),
		.target_o(br_target)
	);

	always_comb begin
		st_nxt = st_r;
		st_nxt.cond_a = branch_condition_inputs_i;
		st_nxt.cond_b = st_r.cond_a;
		st_nxt.exc = 1'b0;
		st_nxt.reg_we = 1'b0;
		st_nxt.mem_req = 1'b0;
		st_nxt.mem_we = 1'b0;
		st_nxt.cop_req = 1'b0;
		st_nxt.cop_kind = BTC_CX_NONE;
		st_nxt.exc_code = BTC_EXC_NONE;
		if (instr_valid_i) begin
			// Sequential advance, or the pending redirect once the slot issues
			st_nxt.pc = st_r.pend ? st_r.pend_tgt : slot_pc;
			st_nxt.pend = 1'b0;
			if (is_br) begin
				st_nxt.pend = br_taken;
				st_nxt.pend_tgt = br_target;
				if (br_link) begin
					st_nxt.reg_we = 1'b1;
					st_nxt.reg_waddr = BTC_LINK_REG;
					st_nxt.reg_wdata = slot_pc + BTC_PC_STEP;
				end
			end else if (op == BTC_OP_SPECIAL && instr_i[5:0] == BTC_FN_SYSTRAP) begin
				st_nxt.exc = 1'b1;
				st_nxt.exc_code = BTC_EXC_SYS;
				st_nxt.pc = BTC_EXC_VECTOR;
				st_nxt.pend = 1'b0;
			end else if (op == BTC_OP_SPECIAL && instr_i[5:0] == BTC_FN_DBGTRAP) begin
				st_nxt.exc = 1'b1;
				st_nxt.exc_code = BTC_EXC_BP;
				st_nxt.pc = BTC_EXC_VECTOR;
				st_nxt.pend = 1'b0;
			end else if (op[5:2] == BTC_OP_COP || op[5:2] == BTC_OP_LWC
					|| op[5:2] == BTC_OP_SWC) begin
				if (cop_z != 2'b00) begin
					st_nxt.exc = 1'b1;
					st_nxt.exc_code = BTC_EXC_CPU;
					st_nxt.pc = BTC_EXC_VECTOR;
					st_nxt.pend = 1'b0;
				end else begin
					st_nxt.cop_req = 1'b1;
					st_nxt.cop_sel = cop_z;
					st_nxt.cop_reg = instr_i[15:11];
					st_nxt.cop_wdata = rt_val_i;
					st_nxt.cop_func = instr_i[24:0];
					if (op[5:2] == BTC_OP_LWC) begin
						st_nxt.mem_req = 1'b1;
						st_nxt.mem_addr = ls_addr;
						st_nxt.cop_kind = BTC_CX_LOAD;
						st_nxt.cop_reg = instr_i[20:16];
						st_nxt.cop_wdata = mem_rdata_i;
					end else if (op[5:2] == BTC_OP_SWC) begin
						st_nxt.mem_req = 1'b1;
						st_nxt.mem_we = 1'b1;
						st_nxt.mem_addr = ls_addr;
						st_nxt.mem_wdata = cop_rdata_i;
						st_nxt.cop_kind = BTC_CX_STORE;
						st_nxt.cop_reg = instr_i[20:16];
					end else if (instr_i[25]) begin
						st_nxt.cop_kind = BTC_CX_OPER;
					end else if (cop_sub == BTC_CO_MT) begin
						st_nxt.cop_kind = BTC_CX_MTD;
					end else if (cop_sub == BTC_CO_CT) begin
						st_nxt.cop_kind = BTC_CX_MTC;
					end else if (cop_sub == BTC_CO_MF || cop_sub == BTC_CO_CF) begin
						st_nxt.cop_kind = (cop_sub == BTC_CO_MF) ? BTC_CX_MFD : BTC_CX_MFC;
						st_nxt.reg_we = 1'b1;
						st_nxt.reg_waddr = instr_i[20:16];
						st_nxt.reg_wdata = cop_rdata_i;
					end else begin
						st_nxt.cop_req = 1'b0;
					end
				end
			end
		end
		st_nxt.fetch_pc = st_nxt.pc;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r <= '0;
			st_r.pc <= BTC_RESET_PC;
			st_r.fetch_pc <= BTC_RESET_PC;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pc_o = st_r.pc;
	assign fetch_pc_o = st_r.fetch_pc;
	assign exc_o = st_r.exc;
	assign exc_code_o = st_r.exc_code;
	assign reg_we_o = st_r.reg_we;
	assign reg_waddr_o = st_r.reg_waddr;
	assign reg_wdata_o = st_r.reg_wdata;
	assign mem_req_o = st_r.mem_req;
	assign mem_we_o = st_r.mem_we;
	assign mem_addr_o = st_r.mem_addr;
	assign mem_wdata_o = st_r.mem_wdata;
	assign cop_req_o = st_r.cop_req;
	assign cop_sel_o = st_r.cop_sel;
	assign cop_kind_o = st_r.cop_kind;
	assign cop_reg_o = st_r.cop_reg;
	assign cop_wdata_o = st_r.cop_wdata;
	assign cop_func_o = st_r.cop_func;

	a_eq_taken: assert property (@(posedge clk_i) disable iff (rst_i)
		(instr_valid_i && op == BTC_OP_BR_EQ && rs_val_i == rt_val_i)
		##1 instr_valid_i |=> (pc_o == $past(st_r.pend_tgt)))
		else $error("equal branch did not redirect after slot");
	a_ne_fall: assert property (@(posedge clk_i) disable iff (rst_i)
		(instr_valid_i && op == BTC_OP_BR_NE && rs_val_i == rt_val_i && !st_r.pend)
		|=> !st_r.pend)
		else $error("unequal branch taken on equal values");
	a_delay_slot: assert property (@(posedge clk_i) disable iff (rst_i)
		(instr_valid_i && is_br && br_taken && !st_r.pend)
		|=> (pc_o == $past(slot_pc)))
		else $error("delay slot skipped");
	a_link_write: assert property (@(posedge clk_i) disable iff (rst_i)
		(instr_valid_i && br_link)
		|=> (reg_we_o && reg_waddr_o == BTC_LINK_REG && reg_wdata_o == pc_o + BTC_PC_STEP))
		else $error("link write wrong");
	a_sys_trap: assert property (@(posedge clk_i) disable iff (rst_i)
		(instr_valid_i && !is_br && op == BTC_OP_SPECIAL && instr_i[5:0] == BTC_FN_SYSTRAP)
		|=> (exc_o && exc_code_o == BTC_EXC_SYS && pc_o == BTC_EXC_VECTOR))
		else $error("system trap not raised");
	a_dbg_trap: assert property (@(posedge clk_i) disable iff (rst_i)
		(instr_valid_i && !is_br && op == BTC_OP_SPECIAL && instr_i[5:0] == BTC_FN_DBGTRAP)
		|=> (exc_o && exc_code_o == BTC_EXC_BP))
		else $error("debug trap not raised");
	a_ls_addr: assert property (@(posedge clk_i) disable iff (rst_i)
		(instr_valid_i && op[5:2] == BTC_OP_LWC && cop_z == 2'b00)
		|=> (mem_req_o && !mem_we_o && mem_addr_o == $past(ls_addr)))
		else $error("load address wrong");
	a_cop_only0: assert property (@(posedge clk_i) disable iff (rst_i)
		(instr_valid_i && op[5:2] == BTC_OP_COP && cop_z != 2'b00 && !is_br)
		|=> (!cop_req_o && exc_o && exc_code_o == BTC_EXC_CPU))
		else $error("non-zero co-processor accepted");
	a_cop_oper: assert property (@(posedge clk_i) disable iff (rst_i)
		(instr_valid_i && op == 6'h10 && instr_i[25])
		|=> (cop_req_o && cop_kind_o == BTC_CX_OPER && !reg_we_o && !mem_req_o))
		else $error("co-processor operation changed state");
	a_ne_taken: assert property (@(posedge clk_i) disable iff (rst_i)
		(instr_valid_i && op == BTC_OP_BR_NE && rs_val_i != rt_val_i)
		|=> st_r.pend)
		else $error("unequal branch not taken on differing values");
	a_eq_fall: assert property (@(posedge clk_i) disable iff (rst_i)
		(instr_valid_i && op == BTC_OP_BR_EQ && rs_val_i != rt_val_i)
		|=> !st_r.pend)
		else $error("equal branch taken on differing values");
	a_npos_branch: assert property (@(posedge clk_i) disable iff (rst_i)
		(instr_valid_i && op == BTC_OP_BR_NPOS)
		|=> (st_r.pend == ($signed($past(rs_val_i)) <= 32'sh0)))
		else $error("nonpositive branch decision wrong");
	a_pos_branch: assert property (@(posedge clk_i) disable iff (rst_i)
		(instr_valid_i && op == BTC_OP_BR_POS)
		|=> (st_r.pend == ($signed($past(rs_val_i)) > 32'sh0)))
		else $error("positive branch decision wrong");
	a_neg_branch: assert property (@(posedge clk_i) disable iff (rst_i)
		(instr_valid_i && op == BTC_OP_BCOND && instr_i[20:16] == 5'h00)
		|=> (st_r.pend == ($signed($past(rs_val_i)) < 32'sh0)))
		else $error("negative branch decision wrong");
	a_nonneg_branch: assert property (@(posedge clk_i) disable iff (rst_i)
		(instr_valid_i && op == BTC_OP_BCOND && instr_i[20:16] == 5'h01)
		|=> (st_r.pend == ($signed($past(rs_val_i)) >= 32'sh0)))
		else $error("nonnegative branch decision wrong");
	a_target_form: assert property (@(posedge clk_i) disable iff (rst_i)
		(instr_valid_i && is_br)
		|=> (st_r.pend_tgt == $past(st_r.pc) + BTC_PC_STEP
			+ $past({{14{instr_i[15]}}, instr_i[15:0], 2'b00})))
		else $error("branch target wrong");
	a_cond_true: assert property (@(posedge clk_i) disable iff (rst_i)
		(instr_valid_i && op[5:2] == BTC_OP_COP && cop_sub == BTC_CO_BC
			&& instr_i[20:16] == 5'h01)
		|=> (st_r.pend == $past(st_r.cond_b[cop_z])))
		else $error("condition true branch wrong");
	a_cond_false: assert property (@(posedge clk_i) disable iff (rst_i)
		(instr_valid_i && op[5:2] == BTC_OP_COP && cop_sub == BTC_CO_BC
			&& instr_i[20:16] == 5'h00)
		|=> (st_r.pend == !$past(st_r.cond_b[cop_z])))
		else $error("condition false branch wrong");
	a_bc_any_unit: assert property (@(posedge clk_i) disable iff (rst_i)
		(instr_valid_i && op[5:2] == BTC_OP_COP && cop_sub == BTC_CO_BC
			&& instr_i[20:17] == 4'h0)
		|=> !exc_o)
		else $error("condition branch refused");
	a_ld_data: assert property (@(posedge clk_i) disable iff (rst_i)
		(instr_valid_i && op[5:2] == BTC_OP_LWC && cop_z == 2'b00)
		|=> (cop_req_o && cop_kind_o == BTC_CX_LOAD && cop_reg_o == $past(instr_i[20:16])
			&& cop_wdata_o == $past(mem_rdata_i)))
		else $error("load word not delivered");
	a_st_data: assert property (@(posedge clk_i) disable iff (rst_i)
		(instr_valid_i && op[5:2] == BTC_OP_SWC && cop_z == 2'b00)
		|=> (mem_req_o && mem_we_o && mem_addr_o == $past(ls_addr)
			&& mem_wdata_o == $past(cop_rdata_i)))
		else $error("store word wrong");
	a_mt_data: assert property (@(posedge clk_i) disable iff (rst_i)
		(instr_valid_i && op == 6'h10 && cop_sub == BTC_CO_MT)
		|=> (cop_req_o && cop_kind_o == BTC_CX_MTD && cop_reg_o == $past(instr_i[15:11])
			&& cop_wdata_o == $past(rt_val_i)))
		else $error("move to data wrong");
	a_mf_data: assert property (@(posedge clk_i) disable iff (rst_i)
		(instr_valid_i && op == 6'h10 && cop_sub == BTC_CO_MF)
		|=> (reg_we_o && reg_waddr_o == $past(instr_i[20:16])
			&& reg_wdata_o == $past(cop_rdata_i)))
		else $error("move from data wrong");
	a_ct_ctl: assert property (@(posedge clk_i) disable iff (rst_i)
		(instr_valid_i && op == 6'h10 && cop_sub == BTC_CO_CT)
		|=> (cop_req_o && cop_kind_o == BTC_CX_MTC && cop_wdata_o == $past(rt_val_i)))
		else $error("move to control wrong");
	a_cf_ctl: assert property (@(posedge clk_i) disable iff (rst_i)
		(instr_valid_i && op == 6'h10 && cop_sub == BTC_CO_CF)
		|=> (reg_we_o && cop_kind_o == BTC_CX_MFC && reg_wdata_o == $past(cop_rdata_i)))
		else $error("move from control wrong");
	a_slot_exec: assert property (@(posedge clk_i) disable iff (rst_i)
		(instr_valid_i && st_r.pend)
		|=> (exc_o || pc_o == $past(st_r.pend_tgt)))
		else $error("redirect lost after slot");
	a_idle_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!instr_valid_i
		|=> (pc_o == $past(pc_o) && !exc_o && !reg_we_o))
		else $error("state moved while stalled");
	a_oper_func: assert property (@(posedge clk_i) disable iff (rst_i)
		(instr_valid_i && op == 6'h10 && instr_i[25])
		|=> (cop_func_o == $past(instr_i[24:0]) && cop_sel_o == 2'h0))
		else $error("operation function not passed");
	a_ldst_only0: assert property (@(posedge clk_i) disable iff (rst_i)
		(instr_valid_i && (op[5:2] == BTC_OP_LWC || op[5:2] == BTC_OP_SWC) && cop_z != 2'b00)
		|=> (exc_o && exc_code_o == BTC_EXC_CPU && !mem_req_o && !cop_req_o))
		else $error("load or store to other unit accepted");
endmodule : btc_exec
`default_nettype wire

// [btc_cop_model.sv]
// Model of the co-processor units and their condition lines
`timescale 1ns/1ns
`default_nettype none
module btc_cop_model
	import btc_pkg::*;
(
	input wire logic clk_i,
	input wire logic [31:0] instr_i,
	input wire logic [3:0] cond_set_i,
	input wire logic cop_req_i,
	input wire logic [1:0] cop_sel_i,
	input wire logic [2:0] cop_kind_i,
	input wire logic [4:0] cop_reg_i,
	input wire logic [31:0] cop_wdata_i,
	output logic [3:0] cond_o,
	output logic [31:0] cop_rdata_o
);
	logic [31:0] regs [0:3][0:1][0:31];
	logic [4:0] idx;
	logic ctl;
	// Condition lines always driven by the units
	assign cond_o = cond_set_i;
	assign idx = (instr_i[31:28] == BTC_OP_SWC) ? instr_i[20:16] : instr_i[15:11];
	assign ctl = (instr_i[31:28] == BTC_OP_COP) && instr_i[22];
	// Unit supplies the addressed register with the instruction
	assign cop_rdata_o = regs[instr_i[27:26]][ctl][idx];
	// Unit accepts loads and moves; operations are taken and ignored
	always @(posedge clk_i) begin
		if (cop_req_i && (cop_kind_i inside {BTC_CX_LOAD, BTC_CX_MTD, BTC_CX_MTC})) begin
			regs[cop_sel_i][cop_kind_i == BTC_CX_MTC][cop_reg_i] <= cop_wdata_i;
		end
	end
endmodule : btc_cop_model
`default_nettype wire

// [btc_exec_tb.sv]
// Self-checking bench for the branch, trap and co-processor unit
`timescale 1ns/1ns
`default_nettype none
`define CK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
	$display("BAD %s exp %h got %h", n, e, g); end end
module btc_exec_tb
	import btc_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic instr_valid_i = 1'b0;
	logic [31:0] instr_i = '0, rs_val_i = '0, rt_val_i = '0, mem_rdata_i = '0;
	logic [3:0] cond_set = '0, cond;
	logic [31:0] cop_rdata, pc_o, fetch_pc_o, reg_wdata_o, mem_addr_o, mem_wdata_o, cop_wdata_o;
	logic exc_o, reg_we_o, mem_req_o, mem_we_o, cop_req_o;
	logic [4:0] exc_code_o, reg_waddr_o, cop_reg_o;
	logic [1:0] cop_sel_o;
	logic [2:0] cop_kind_o;
	logic [24:0] cop_func_o;
	logic [31:0] epc;
	int errors = 0;
	int tests_run = 0;
	always #5 clk_i = ~clk_i;
	btc_exec u_dut (.clk_i, .rst_i, .instr_valid_i, .instr_i, .rs_val_i, .rt_val_i,
		.branch_condition_inputs_i(cond), .mem_rdata_i, .cop_rdata_i(cop_rdata), .pc_o,
		.fetch_pc_o, .exc_o, .exc_code_o, .reg_we_o, .reg_waddr_o, .reg_wdata_o, .mem_req_o,
		.mem_we_o, .mem_addr_o, .mem_wdata_o, .cop_req_o, .cop_sel_o, .cop_kind_o, .cop_reg_o,
		.cop_wdata_o, .cop_func_o);
	btc_cop_model u_cop (.clk_i, .instr_i, .cond_set_i(cond_set), .cop_req_i(cop_req_o),
		.cop_sel_i(cop_sel_o), .cop_kind_i(cop_kind_o), .cop_reg_i(cop_reg_o),
		.cop_wdata_i(cop_wdata_o), .cond_o(cond), .cop_rdata_o(cop_rdata));
	task automatic close_out();
		$display("checks %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : close_out
	task automatic ex(input logic [31:0] ins, rs, rt);
		instr_valid_i = 1'b1;
		instr_i = ins;
		rs_val_i = rs;
		rt_val_i = rt;
		@(negedge clk_i);
	endtask : ex
	task automatic idle(input int n);
		instr_valid_i = 1'b0;
		repeat (n) @(negedge clk_i);
	endtask : idle
	task automatic br(input logic [31:0] ins, rs, rt, input logic take, lnk);
		logic [31:0] p, dst, d;
		logic we;
		p = epc;
		dst = take ? p + 32'h4 + {{14{ins[15]}}, ins[15:0], 2'b00} : p + 32'h8;
		ex(ins, rs, rt);
		`CK("slot pc", p + 32'h4, pc_o)
		we = reg_we_o;
		d = reg_wdata_o;
		ex(32'h0, 32'h0, 32'h0);
		if (reg_we_o === 1'b1) d = reg_wdata_o;
		we = we | reg_we_o;
		`CK("target", dst, pc_o)
		`CK("fetch", dst, fetch_pc_o)
		`CK("link we", lnk, we)
		if (lnk) `CK("link data", p + 32'h8, d)
		epc = dst;
	endtask : br
	task automatic t_cmp;
		br({6'h04, 10'h0, 16'hfff0}, 32'h5, 32'h5, 1'b1, 1'b0);
		br({6'h04, 10'h0, 16'h0010}, 32'h5, 32'h6, 1'b0, 1'b0);
		br({6'h05, 10'h0, 16'h0010}, 32'h5, 32'h6, 1'b1, 1'b0);
		br({6'h05, 10'h0, 16'h8000}, 32'h7, 32'h7, 1'b0, 1'b0);
		idle(1);
		$display("t_cmp done");
	endtask : t_cmp
	task automatic t_zero;
		logic [31:0] v [4] = '{32'h0, 32'h1, 32'h8000_0000, 32'hffff_ffff};
		for (int i = 0; i < 4; i++) begin
			br({6'h06, 10'h0, 16'h0003}, v[i], 0, v[i][31] | (v[i] == 0), 1'b0);
			br({6'h07, 10'h0, 16'h0003}, v[i], 0, !v[i][31] && v[i] != 0, 1'b0);
			br({BTC_OP_BCOND, 10'h0, 16'h0005}, v[i], 0, v[i][31], 1'b0);
			br({BTC_OP_BCOND, 10'h1, 16'h0005}, v[i], 0, !v[i][31], 1'b0);
		end
		idle(1);
		$display("t_zero done");
	endtask : t_zero
	task automatic t_link;
		br({BTC_OP_BCOND, 10'h10, 16'h0040}, 32'h1, 0, 1'b0, 1'b1);
		br({BTC_OP_BCOND, 10'h11, 16'hffe0}, 32'h0, 0, 1'b1, 1'b1);
		idle(1);
		$display("t_link done");
	endtask : t_link
	task automatic t_trap;
		ex({26'h0, BTC_FN_SYSTRAP}, 0, 0);
		`CK("sys code", BTC_EXC_SYS, exc_code_o)
		`CK("sys pc", BTC_EXC_VECTOR, pc_o)
		ex({26'h0, BTC_FN_DBGTRAP}, 0, 0);
		`CK("bp exc", 1'b1, exc_o)
		`CK("bp code", BTC_EXC_BP, exc_code_o)
		epc = BTC_EXC_VECTOR;
		idle(1);
		$display("t_trap done");
	endtask : t_trap
	task automatic t_cop;
		mem_rdata_i = 32'h1234_5678;
		ex({BTC_OP_LWC, 2'h0, 5'h0, 5'h3, 16'hfffc}, 32'h100, 0);
		`CK("ld addr", 32'h0000_00fc, mem_addr_o)
		`CK("ld kind", BTC_CX_LOAD, cop_kind_o)
		`CK("ld sel", 2'h0, cop_sel_o)
		`CK("ld data", 32'h1234_5678, cop_wdata_o)
		idle(1);
		ex({BTC_OP_SWC, 2'h0, 5'h0, 5'h3, 16'h0008}, 32'h200, 0);
		`CK("st we", 1'b1, mem_we_o)
		`CK("st data", 32'h1234_5678, mem_wdata_o)
		ex({BTC_OP_COP, 2'h0, BTC_CO_MT, 10'h5, 11'h0}, 0, 32'hcafe_0001);
		`CK("mt kind", BTC_CX_MTD, cop_kind_o)
		`CK("mt reg", 5'h5, cop_reg_o)
		ex({BTC_OP_COP, 2'h0, BTC_CO_CT, 10'h5, 11'h0}, 0, 32'hbeef_0002);
		`CK("ct kind", BTC_CX_MTC, cop_kind_o)
		idle(1);
		ex({BTC_OP_COP, 2'h0, BTC_CO_MF, 10'he5, 11'h0}, 0, 0);
		`CK("mf addr", 5'h7, reg_waddr_o)
		`CK("mf data", 32'hcafe_0001, reg_wdata_o)
		ex({BTC_OP_COP, 2'h0, BTC_CO_CF, 10'h105, 11'h0}, 0, 0);
		`CK("cf data", 32'hbeef_0002, reg_wdata_o)
		ex({BTC_OP_COP, 2'h0, 1'b1, 25'h0abcde}, 0, 0);
		`CK("op func", 25'h0abcde, cop_func_o)
		`CK("op we", 1'b0, reg_we_o | mem_req_o)
		ex({BTC_OP_COP, 2'h1, BTC_CO_MT, 10'h5, 11'h0}, 0, 0);
		`CK("z1 code", BTC_EXC_CPU, exc_code_o)
		`CK("z1 req", 1'b0, cop_req_o)
		epc = BTC_EXC_VECTOR;
		idle(1);
		$display("t_cop done");
	endtask : t_cop
	task automatic t_cond;
		cond_set = 4'h2;
		idle(3);
		br({BTC_OP_COP, 2'h1, BTC_CO_BC, 5'h1, 16'h0004}, 0, 0, 1'b1, 1'b0);
		br({BTC_OP_COP, 2'h1, BTC_CO_BC, 5'h0, 16'h0004}, 0, 0, 1'b0, 1'b0);
		cond_set = 4'hd;
		idle(3);
		br({BTC_OP_COP, 2'h1, BTC_CO_BC, 5'h0, 16'hfffc}, 0, 0, 1'b1, 1'b0);
		idle(1);
		$display("t_cond done");
	endtask : t_cond
	initial begin
		for (int i = 0; i < 20000; i++) @(posedge clk_i);
		errors++;
		close_out();
	end
	initial begin
		repeat (3) @(negedge clk_i);
		`CK("reset pc", BTC_RESET_PC, pc_o)
		rst_i = 1'b0;
		epc = BTC_RESET_PC;
		t_cmp();
		t_zero();
		t_link();
		t_trap();
		t_cop();
		t_cond();
		close_out();
	end
endmodule : btc_exec_tb
`default_nettype wire
